// [verilog/ast_top.sv]
// Conversion status tracker: flags, conversion counter, APB regs, IRQ.
// Assumes conv_done, result_ccf_set and result_data come from the sequencer on pclk.
module ast_top
	import ast_pkg::*;
#(
	parameter int SEQ_LEN = 8
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pen,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        trig_pin,
	input  wire logic        conv_done,
	input  wire logic        result_ccf_set,
	input  wire logic [7:0]  result_data,
	output logic             seq_running,
	output logic             seq_abort,
	output logic             seq_start,
	output logic [3:0]       conversion_counter,
	output logic             irq
);
	// Slot index is 4 bits, so a sequence fits in at most sixteen slots
	if (SEQ_LEN < 1 || SEQ_LEN > 16) begin : g_len_chk
		$error("SEQ_LEN out of range");
	end
	ast_ev_if ev ();
	ast_apb_dec u_dec (
		.pen    (pen),
		.psel   (psel),
		.penable(penable),
		.pwrite (pwrite),
		.paddr  (paddr),
		.pwdata (pwdata[7:0]),
		.ev     (ev)
	);

	// Trigger pin synchroniser; first stage feeds only the second
	logic trig_s1, trig_s2, trig_d;
	logic [7:0] mode, irq_mask, status;
	logic [7:0] next_mode, next_irq_mask;
	logic sequence_complete_flag, trigger_overrun_flag, result_overrun_flag;
	logic next_scf, next_trigger_overrun_flag, next_result_overrun_flag;
	logic [3:0] next_cc, seq_cnt, next_seq_cnt;
	ast_state_t state, next_state;
	logic trig_edge, trig_start, last_conv, any_clear;
	logic [7:0] results [16];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_d  <= 1'b0;
		end else if (pen) begin
			trig_s1 <= trig_pin;
			trig_s2 <= trig_s1;
			trig_d  <= trig_s2;
		end
	end

	always_comb begin
		trig_edge  = trig_s2 && !trig_d;
		trig_start = mode[MODE_LEVEL] ? trig_s2 : trig_edge;
		last_conv  = conv_done && seq_cnt == 4'(SEQ_LEN - 1);
		any_clear  = ev.abort_wr || ev.start_wr;
		seq_abort  = ev.abort_wr;
		seq_start  = ev.start_wr;
		seq_running = state == AST_RUN;
	end

	function automatic logic reg_wr(input logic [7:0] a);
		return pen && psel && penable && pwrite && paddr == a;
	endfunction

	// Config registers
	always_comb begin
		next_mode     = mode;
		next_irq_mask = irq_mask;
		if (reg_wr(ADDR_MODE))
			next_mode = pwdata[7:0];
		if (reg_wr(ADDR_IRQ_MASK))
			next_irq_mask = pwdata[7:0] & FLAG_MASK;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode     <= MODE_RESET;
			irq_mask <= MASK_RESET;
		end else if (pen) begin
			mode     <= next_mode;
			irq_mask <= next_irq_mask;
		end
	end

	// Sequencer state, flags and counter
	always_comb begin
		next_state   = state;
		next_seq_cnt = seq_cnt;
		next_cc      = conversion_counter;
		next_scf     = sequence_complete_flag;
		next_trigger_overrun_flag   = trigger_overrun_flag;
		next_result_overrun_flag   = result_overrun_flag;
		// Clears first so that a same-cycle set wins
		if (ev.status_wr && ev.wdata[SCF_BIT])
			next_scf = 1'b0;
		if (ev.status_wr && ev.wdata[TRIGGER_OVERRUN_FLAG_BIT])
			next_trigger_overrun_flag = 1'b0;
		if (ev.status_wr && ev.wdata[RESULT_OVERRUN_FLAG_BIT])
			next_result_overrun_flag = 1'b0;
		if (ev.result_rd && mode[MODE_AUTO_FLAG_FAST_CLEAR])
			next_scf = 1'b0;
		if (ev.start_wr)
			next_scf = 1'b0;
		if (any_clear) begin
			next_trigger_overrun_flag = 1'b0;
			next_result_overrun_flag = 1'b0;
		end
		case (state)
			AST_IDLE: begin
				if (!any_clear && trig_start) begin
					next_state   = AST_RUN;
					next_seq_cnt = 4'h0;
					if (!mode[MODE_FIFO])
						next_cc = 4'h0;
				end
			end
			AST_RUN: begin
				if (trig_edge && !mode[MODE_LEVEL])
					next_trigger_overrun_flag = 1'b1;
				if (conv_done) begin
					if (result_ccf_set)
						next_result_overrun_flag = 1'b1;
					next_cc      = conversion_counter + 4'h1;
					next_seq_cnt = seq_cnt + 4'h1;
				end
				if (last_conv) begin
					next_scf     = 1'b1;
					next_seq_cnt = 4'h0;
					if (!mode[MODE_FIFO])
						next_cc = 4'h0;
					if (!mode[MODE_SCAN])
						next_state = AST_IDLE;
				end
			end
			default: next_state = AST_IDLE;
		endcase
		if (ev.abort_wr) begin
			next_state   = AST_IDLE;
			next_seq_cnt = 4'h0;
			next_cc      = 4'h0;
		end
		if (ev.start_wr) begin
			next_state   = AST_RUN;
			next_seq_cnt = 4'h0;
			next_cc      = 4'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                  <= AST_IDLE;
			seq_cnt                <= 4'h0;
			conversion_counter     <= 4'h0;
			sequence_complete_flag <= 1'b0;
			trigger_overrun_flag   <= 1'b0;
			result_overrun_flag    <= 1'b0;
		end else if (pen) begin
			state                  <= next_state;
			seq_cnt                <= next_seq_cnt;
			conversion_counter     <= next_cc;
			sequence_complete_flag <= next_scf;
			trigger_overrun_flag   <= next_trigger_overrun_flag;
			result_overrun_flag    <= next_result_overrun_flag;
		end
	end

	// Result store indexed by the counter
	always_ff @(posedge pclk) begin
		if (pen && state == AST_RUN && conv_done)
			results[conversion_counter] <= result_data;
	end

	// APB read path; zero wait states
	always_comb begin
		status = {sequence_complete_flag, 1'b0, trigger_overrun_flag,
			result_overrun_flag, conversion_counter};
		pready  = 1'b1;
		pslverr = 1'b0;
		irq     = |(status & irq_mask & FLAG_MASK);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (pen && psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_STATUS:   prdata <= {24'h00_0000, status};
				ADDR_MODE:     prdata <= {24'h00_0000, mode};
				ADDR_IRQ_MASK: prdata <= {24'h00_0000, irq_mask};
				default: begin
					if (paddr[7:6] == ADDR_RESULT[7:6])
						prdata <= {24'h00_0000, results[paddr[5:2]]};
					else
						prdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Assertions
	// Set conditions; a set in the same cycle beats any clear
	logic scf_set, trigger_overrun_flag_set, result_overrun_flag_set;
	always_comb begin
		scf_set   = seq_running && last_conv;
		trigger_overrun_flag_set = seq_running && trig_edge && !mode[MODE_LEVEL];
		result_overrun_flag_set = seq_running && conv_done && result_ccf_set;
	end

	a_start_clears_cc: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.start_wr
		|=> conversion_counter == 4'h0 && seq_running)
		else $error("start did not clear counter");

	a_abort_idles: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.abort_wr && !ev.start_wr
		|=> !seq_running)
		else $error("abort did not stop sequence");

	a_abort_flags: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.abort_wr && !trigger_overrun_flag_set && !result_overrun_flag_set
		|=> !trigger_overrun_flag && !result_overrun_flag)
		else $error("abort did not clear overruns");

	a_abort_cc: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.abort_wr
		|=> conversion_counter == 4'h0)
		else $error("abort did not clear counter");

	a_scf_sets: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && seq_running && last_conv && !any_clear
		|=> sequence_complete_flag)
		else $error("scf not set");

	a_scf_start_clr: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.start_wr && !scf_set
		|=> !sequence_complete_flag)
		else $error("scf not cleared by start");

	a_scf_w1c: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.status_wr && ev.wdata[SCF_BIT] && !scf_set
		|=> !sequence_complete_flag)
		else $error("scf not cleared by write one");

	a_fast_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.result_rd && mode[MODE_AUTO_FLAG_FAST_CLEAR] && !scf_set
		|=> !sequence_complete_flag)
		else $error("scf not cleared by result read");

	a_trigger_overrun_flag_sets: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && seq_running && trig_edge && !mode[MODE_LEVEL] && !any_clear
		|=> trigger_overrun_flag)
		else $error("trigger_overrun_flag not set");

	// Level mode restarts on the pin, so it never counts an overrun
	a_trigger_overrun_flag_level: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && mode[MODE_LEVEL] && !trigger_overrun_flag
		|=> !trigger_overrun_flag)
		else $error("trigger_overrun_flag set in level mode");

	a_trigger_overrun_flag_w1c: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.status_wr && ev.wdata[TRIGGER_OVERRUN_FLAG_BIT] && !trigger_overrun_flag_set
		|=> !trigger_overrun_flag)
		else $error("trigger_overrun_flag not cleared by write one");

	a_trigger_overrun_flag_start_clr: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.start_wr && !trigger_overrun_flag_set
		|=> !trigger_overrun_flag)
		else $error("trigger_overrun_flag not cleared by start");

	a_result_overrun_flag_sets: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && seq_running && conv_done && result_ccf_set && !any_clear
		|=> result_overrun_flag)
		else $error("result_overrun_flag not set");

	a_result_overrun_flag_w1c: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.status_wr && ev.wdata[RESULT_OVERRUN_FLAG_BIT] && !result_overrun_flag_set
		|=> !result_overrun_flag)
		else $error("result_overrun_flag not cleared by write one");

	a_status_wr_cc: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.status_wr && !seq_running && !any_clear && !trig_start
		|=> $stable(conversion_counter))
		else $error("cc changed");

	a_zero_keeps: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && ev.status_wr && ev.wdata[RESULT_OVERRUN_FLAG_BIT] == 1'b0 && !any_clear
		&& result_overrun_flag
		|=> result_overrun_flag)
		else $error("zero write cleared flag");

	a_nonfifo_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && seq_running && last_conv && !mode[MODE_FIFO] && !any_clear
		|=> conversion_counter == 4'h0)
		else $error("cc not zeroed");

	// Counter is 4 bits, so slot 15 rolls over to slot 0
	a_fifo_wrap: assert property (
		@(posedge pclk) disable iff (!presetn)
		pen && seq_running && conv_done && mode[MODE_FIFO] && !any_clear
		|=> conversion_counter == $past(conversion_counter) + 4'h1)
		else $error("fifo counter did not advance");

	a_frozen_state: assert property (
		@(posedge pclk) disable iff (!presetn)
		!pen
		|=> $stable(conversion_counter) && $stable(sequence_complete_flag)
		&& $stable(prdata))
		else $error("state moved with enable low");

	a_seq_cnt_range: assert property (
		@(posedge pclk) disable iff (!presetn)
		int'(seq_cnt) < SEQ_LEN)
		else $error("sequence count out of range");

	c_seq_done: cover property (@(posedge pclk) seq_running && last_conv);
	c_fifo_wrap: cover property (@(posedge pclk)
		mode[MODE_FIFO] && conversion_counter == 4'hF && conv_done);
	c_trigger_overrun_flag: cover property (@(posedge pclk) $rose(trigger_overrun_flag));
	c_result_overrun_flag: cover property (@(posedge pclk) $rose(result_overrun_flag));
	c_irq: cover property (@(posedge pclk) $rose(irq));
endmodule

// [verilog/ast_pkg.sv]
// Constants and types for the conversion status tracker.
// Assumes an APB slave on pclk; sequencer events arrive on pclk.
package ast_pkg;
	localparam logic [7:0] ADDR_CTL0     = 8'h00;
	localparam logic [7:0] ADDR_CTL4     = 8'h10;
	localparam logic [7:0] ADDR_START    = 8'h14;
	localparam logic [7:0] ADDR_STATUS   = 8'h18;
	localparam logic [7:0] ADDR_CMPE     = 8'h1C;
	localparam logic [7:0] ADDR_CMPHT    = 8'h20;
	localparam logic [7:0] ADDR_MODE     = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
	localparam logic [7:0] ADDR_RESULT   = 8'h40;
	localparam int         NUM_CTL       = 5;
	localparam int         SCF_BIT       = 7;
	localparam int         TRIGGER_OVERRUN_FLAG_BIT     = 5;
	localparam int         RESULT_OVERRUN_FLAG_BIT     = 4;
	localparam int         CC_LSB        = 0;
	localparam int         MODE_SCAN     = 0;
	localparam int         MODE_FIFO     = 1;
	localparam int         MODE_AUTO_FLAG_FAST_CLEAR     = 2;
	localparam int         MODE_LEVEL    = 3;
	localparam logic [7:0] FLAG_MASK     = 8'hB0;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] MASK_RESET    = 8'h00;
	typedef enum logic [1:0] {AST_IDLE, AST_RUN} ast_state_t;
endpackage

// [verilog/ast_ev_if.sv]
// Event bundle from the APB decoder to the tracker core.
// Assumes single clock pclk.
interface ast_ev_if;
	logic       abort_wr;
	logic       start_wr;
	logic       result_rd;
	logic       status_wr;
	logic [7:0] wdata;
	modport dec  (output abort_wr, start_wr, result_rd, status_wr, wdata);
	modport core (input  abort_wr, start_wr, result_rd, status_wr, wdata);
endinterface

// [verilog/ast_apb_dec.sv]
// APB write/read decode into one-cycle sequencer events.
// Assumes APB access phase completes in one cycle (pready tied high).
module ast_apb_dec
	import ast_pkg::*;
(
	input  wire logic       pen,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [7:0] pwdata,
	ast_ev_if.dec           ev
);
	logic acc;
	function automatic logic is_abort(input logic [7:0] a);
		return (a >= ADDR_CTL0 && a <= ADDR_CTL4) || a == ADDR_CMPE
			|| a == ADDR_CMPHT;
	endfunction
	always_comb begin
		acc          = pen && psel && penable;
		ev.abort_wr  = acc && pwrite && is_abort(paddr);
		ev.start_wr  = acc && pwrite && paddr == ADDR_START;
		ev.status_wr = acc && pwrite && paddr == ADDR_STATUS;
		ev.result_rd = acc && !pwrite && paddr[7:6] == ADDR_RESULT[7:6];
		ev.wdata     = pwdata;
	end
endmodule

// [sim/ast_seq_model.sv]
// Sequencer stand-in: conversion pulses, result bytes, slot flags.
// Assumes the tracker's running and counter outputs on pclk.
module ast_seq_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       seq_running,
	input  wire logic [3:0] conversion_counter,
	input  wire logic       slow,
	input  wire logic       ccf_clr,
	output logic            conv_done,
	output logic            result_ccf_set,
	output logic [7:0]      result_data
);
	logic [15:0] ccf;
	logic [2:0]  gap;

	// Flags stay set until the bench drains them, like unread results
	assign result_ccf_set = ccf[conversion_counter];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_done   <= 1'b0;
			gap         <= 3'h0;
			ccf         <= 16'h0000;
			result_data <= 8'h00;
		end else begin
			// Churns every cycle so a stale byte never looks valid
			result_data <= result_data + 8'h01;
			if (ccf_clr)
				ccf <= 16'h0000;
			else if (conv_done)
				ccf[conversion_counter] <= 1'b1;
			if (conv_done || !seq_running) begin
				conv_done <= 1'b0;
				gap       <= slow ? 3'h6 : 3'h0;
			end else if (gap != 3'h0)
				gap <= gap - 3'h1;
			else
				conv_done <= 1'b1;
		end
	end
endmodule

// [sim/tb_adc_sequence_status_tracker.sv]
// Bench for ast_top: APB master, abort/start row table, flag cases.
// Assumes ast_pkg, ast_seq_model and the design's own assertions.
module tb_adc_sequence_status_tracker
	import ast_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] addr; logic run;} ast_row_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        trig_pin = 1'b0;
	logic        slow = 1'b1;
	logic        ccf_clr = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, conv_done, result_ccf_set, irq;
	logic        seq_running, seq_abort, seq_start;
	logic [7:0]  result_data;
	logic [3:0]  conversion_counter;
	int          fail_count = 0;
	int          compares = 0;
	int          cycles = 0;
	ast_row_t    rows [8] = '{'{ADDR_CTL0, 1'b0}, '{8'h04, 1'b0},
		'{8'h08, 1'b0}, '{8'h0C, 1'b0}, '{ADDR_CTL4, 1'b0},
		'{ADDR_CMPE, 1'b0}, '{ADDR_CMPHT, 1'b0}, '{ADDR_START, 1'b1}};
	logic [7:0]  reset_addr [4] = '{ADDR_STATUS, ADDR_MODE,
		ADDR_IRQ_MASK, 8'h30};

	ast_top i_dut (.pclk(pclk), .presetn(presetn), .pen(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trig_pin(trig_pin), .conv_done(conv_done),
		.result_ccf_set(result_ccf_set), .result_data(result_data),
		.seq_running(seq_running), .seq_abort(seq_abort),
		.seq_start(seq_start), .conversion_counter(conversion_counter),
		.irq(irq));
	ast_seq_model i_seq (.pclk(pclk), .presetn(presetn),
		.seq_running(seq_running), .conversion_counter(conversion_counter),
		.slow(slow), .ccf_clr(ccf_clr), .conv_done(conv_done),
		.result_ccf_set(result_ccf_set), .result_data(result_data));

	always #2.5 pclk = ~pclk;

	task automatic conclude();
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Idle cycle first so back-to-back calls never drive psel twice
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask

	task automatic conv(input int n);
		int k = 0;
		while (k < n) begin
			@(posedge pclk);
			if (conv_done === 1'b1)
				k++;
		end
	endtask

	task automatic clr_ccf();
		@(posedge pclk);
		ccf_clr <= 1'b1;
		@(posedge pclk);
		ccf_clr <= 1'b0;
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (reset_addr[i]) begin
			rdr(reset_addr[i]);
			chk("reset read", rd, 32'h0);
		end
		chk("irq", 32'(irq), 32'h0);
		foreach (rows[i]) begin
			wr(ADDR_START, 8'h00);
			conv(3);
			wr(rows[i].addr, 8'h00);
			@(posedge pclk);
			chk("running", 32'(seq_running), 32'(rows[i].run));
			chk("counter", 32'(conversion_counter), 32'h0);
		end
		conv(8);
		@(posedge pclk);
		chk("counter", 32'(conversion_counter), 32'h0);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'h8F, 32'h80);
		wr(ADDR_STATUS, 8'h30);
		rdr(ADDR_STATUS);
		chk("status", rd, 32'h80);
		wr(ADDR_IRQ_MASK, 8'hB0);
		@(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		wr(ADDR_STATUS, 8'h80);
		@(posedge pclk);
		chk("irq", 32'(irq), 32'h0);
		clr_ccf();
		slow <= 1'b0;
		wr(ADDR_MODE, 8'h04);
		wr(ADDR_START, 8'h00);
		conv(8);
		rdr(ADDR_STATUS);
		chk("status", rd, 32'h80);
		rdr(ADDR_RESULT);
		rdr(ADDR_STATUS);
		chk("status", rd, 32'h0);
		clr_ccf();
		slow <= 1'b1;
		wr(ADDR_MODE, 8'h00);
		trig_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("running", 32'(seq_running), 32'h1);
		trig_pin <= 1'b0;
		repeat (3) @(posedge pclk);
		trig_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'h20, 32'h20);
		wr(ADDR_START, 8'h00);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'hB0, 32'h0);
		trig_pin <= 1'b0;
		conv(8);
		clr_ccf();
		slow <= 1'b0;
		wr(ADDR_MODE, 8'h02);
		wr(ADDR_START, 8'h00);
		conv(8);
		@(posedge pclk);
		chk("counter", 32'(conversion_counter), 32'h8);
		wr(ADDR_STATUS, 8'hFF);
		rdr(ADDR_STATUS);
		chk("status", rd, 32'h08);
		clr_ccf();
		slow <= 1'b1;
		wr(ADDR_IRQ_MASK, 8'h10);
		wr(ADDR_MODE, 8'h03);
		wr(ADDR_START, 8'h00);
		conv(16);
		@(posedge pclk);
		chk("counter", 32'(conversion_counter), 32'h0);
		chk("irq", 32'(irq), 32'h0);
		conv(1);
		@(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		wr(ADDR_STATUS, 8'h20);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'h10, 32'h10);
		wr(ADDR_CTL0, 8'h00);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'hB0, 32'h80);
		chk("running", 32'(seq_running), 32'h0);
		chk("slave error", 32'(pslverr), 32'h0);
		wr(ADDR_MODE, 8'h08);
		trig_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("running", 32'(seq_running), 32'h1);
		trig_pin <= 1'b0;
		repeat (3) @(posedge pclk);
		trig_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		rdr(ADDR_STATUS);
		chk("status", rd & 32'h20, 32'h0);
		trig_pin <= 1'b0;
		conclude();
	end
endmodule
